/* File: hdl/serial_status_pkg.sv */
// Behaviour
// - status register loads 87h on reset and on standby entry.
// - software clears flags only by writing 0; writing 1 changes nothing.
// - tx-empty flag clears on write 0 only after being read as 1.
// - tx-empty flag clears when the transfer controller writes the buffer.
// - tx-empty flag sets when buffer moves into the shift register.
// - tx-empty flag sets when transmit enable is cleared from 1 to 0.
// - rx-full flag clears on write 0 after being read as 1.
// - rx-full flag clears when the transfer controller reads the buffer.
// - rx-full flag sets only on an error-free character moved to buffer.
// - overrun flag sets when a reception completes while rx-full is set.
// - framing flag sets when the received stop bit samples 0 and rx-full is clear.
// - parity flag sets on mismatch with rx-full clear, async mode with parity only.
// - error flags clear on read-then-write-0, reset or standby.
// - status bits 2..0 cannot be written and read as 1.
// - 8-bit divisor with prescaler sets rate; resets to FFh.
// - prescaler code 0..3 divides the system clock by 1, 4, 16, 64.
// - async bit rate is clock / (64 * 4^n * (divisor + 1)).
// - sync bit rate is clock / (8 * 4^n * (divisor + 1)).
// - rx interrupt enable gates rx-complete and rx-error; tx interrupt enable gates tx-empty.
package serial_status_pkg;

  // ==========================================================
  // register map (word indices; byte address is index * 4)
  localparam logic [15:0] BIT_RATE_DIVISOR_IDX   = 16'hFFD9;
  localparam logic [15:0] SERIAL_LINE_STATUS_IDX = 16'hFFDC;
  localparam logic [15:0] SERIAL_CONTROL_IDX     = 16'hFFE0;
  localparam int          IDX_LSB                = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] STATUS_RESET  = 8'h87;
  localparam logic [7:0] DIVISOR_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [2:0] STATUS_FIXED  = 3'h7;

  // ==========================================================
  // status flag vector positions (flag vector = status bits 7..3)
  localparam int FLAG_LSB    = 3;
  localparam int F_TX_EMPTY  = 4;
  localparam int F_RX_FULL   = 3;
  localparam int F_OVERRUN   = 2;
  localparam int F_FRAMING   = 1;
  localparam int F_PARITY    = 0;

  // ==========================================================
  // control register fields
  localparam int C_PRESC_LO  = 0;
  localparam int C_PRESC_HI  = 1;
  localparam int C_SYNC_MODE = 2;
  localparam int C_PARITY_EN = 3;
  localparam int C_TX_EN     = 5;
  localparam int C_RX_IE     = 6;
  localparam int C_TX_IE     = 7;

  // ==========================================================
  // bit rate generator
  localparam logic [5:0] PRESC_MASK_DIV1  = 6'h00;
  localparam logic [5:0] PRESC_MASK_DIV4  = 6'h03;
  localparam logic [5:0] PRESC_MASK_DIV16 = 6'h0F;
  localparam logic [5:0] PRESC_MASK_DIV64 = 6'h3F;
  localparam logic [5:0] ASYNC_POST_LAST  = 6'h3F;
  localparam logic [5:0] SYNC_POST_LAST   = 6'h07;

  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : serial_status_pkg

/* File: hdl/bit_rate_gen.sv */
module bit_rate_gen
  import serial_status_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       standby_in,
  // settings
  input  wire logic [1:0] prescale_sel_in,
  input  wire logic [7:0] divisor_in,
  // output
  output logic            gen_tick_out
);
  import serial_status_pkg::*;

  typedef struct packed {
    logic [5:0] presc_cnt;
    logic [7:0] div_cnt;
    logic       tick;
  } gen_state_type;

  gen_state_type q;
  gen_state_type n;
  logic [5:0]    mask;
  logic          presc_tick;

  always_comb begin
    case (prescale_sel_in)
      2'h0:    mask = PRESC_MASK_DIV1;
      2'h1:    mask = PRESC_MASK_DIV4;
      2'h2:    mask = PRESC_MASK_DIV16;
      2'h3:    mask = PRESC_MASK_DIV64;
      default: mask = PRESC_MASK_DIV1;
    endcase
    presc_tick = ((q.presc_cnt & mask) == mask);
  end

  always_comb begin
    n           = q;
    n.tick      = 1'b0;
    n.presc_cnt = q.presc_cnt + 6'h01;
    if (presc_tick) begin
      if (q.div_cnt == 8'h00) begin
        n.div_cnt = divisor_in;
        n.tick    = 1'b1;
      end else begin
        n.div_cnt = q.div_cnt - 8'h01;
      end
    end
    // standby restarts the divider chain from a clean phase
    if (standby_in) begin
      n = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign gen_tick_out = q.tick;

endmodule // bit_rate_gen

/* File: hdl/serial_status_and_bit_rate.sv */
module serial_status_and_bit_rate
  import serial_status_pkg::*;
#(
  parameter int ADDR_W = 18
)(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic              standby_in,
  // axi4-lite write address / data / response
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  output logic [1:0]             s_axi_bresp_out,
  // axi4-lite read address / data
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  // shifter and transfer controller events
  input  wire logic              tx_load_in,
  input  wire logic              xfer_tx_write_in,
  input  wire logic              xfer_rx_read_in,
  input  wire logic              rx_done_in,
  input  wire logic              rx_stop_bit_in,
  input  wire logic              rx_parity_bad_in,
  // to the rest of the interface
  output logic                   rx_buffer_load_out,
  output logic                   bit_tick_out,
  output logic                   transmit_enable_out,
  output logic                   sync_mode_out,
  output logic                   rx_complete_request_out,
  output logic                   rx_error_request_out,
  output logic                   tx_empty_request_out
);
  import serial_status_pkg::*;

  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [7:0]        w_byte;
    logic              w_lane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [4:0]        flags;
    logic [4:0]        armed;
    logic [7:0]        divisor;
    logic [7:0]        ctrl;
    logic [5:0]        post_cnt;
    logic              bit_tick;
    logic              rx_load;
  } state_type;

  state_type   q;
  state_type   n;
  logic        gen_tick;
  logic [15:0] ar_idx;
  logic [15:0] aw_idx;
  logic        do_wr;
  logic        tx_en_fall;
  logic [4:0]  sw_clr;
  logic [4:0]  hw_set;
  logic [4:0]  hw_clr;
  logic        framing_hit;
  logic        parity_hit;

  // ==========================================================
  // bit rate generator
  bit_rate_gen u_gen (
    .mclk_in         (mclk_in),
    .nrst_in         (nrst_in),
    .standby_in      (standby_in),
    .prescale_sel_in ({q.ctrl[C_PRESC_HI], q.ctrl[C_PRESC_LO]}),
    .divisor_in      (q.divisor),
    .gen_tick_out    (gen_tick)
  );

  assign ar_idx = s_axi_araddr_in[IDX_LSB +: 16];
  assign aw_idx = q.aw_addr[IDX_LSB +: 16];
  assign do_wr  = q.aw_held && q.w_held && !q.bvalid;

  // ==========================================================
  // next state
  always_comb begin
    n          = q;
    n.bit_tick = 1'b0;
    n.rx_load  = 1'b0;
    sw_clr     = '0;
    hw_set     = '0;
    hw_clr     = '0;
    tx_en_fall = 1'b0;
    framing_hit = 1'b0;
    parity_hit  = 1'b0;

    // read channel: one read in flight, answer one cycle after address
    if (q.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      case (ar_idx)
        BIT_RATE_DIVISOR_IDX: n.rdata = q.divisor;
        SERIAL_LINE_STATUS_IDX: begin
          n.rdata = {q.flags, STATUS_FIXED};
          // a flag seen as 1 may now be cleared by writing 0
          n.armed = q.armed | q.flags;
        end
        SERIAL_CONTROL_IDX: n.rdata = q.ctrl;
        default: begin
          n.rdata = 8'h00;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // write channel: address and data taken in either order
    if (q.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid_in && !q.aw_held) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !q.w_held) begin
      n.w_held = 1'b1;
      n.w_byte = s_axi_wdata_in[7:0];
      n.w_lane = s_axi_wstrb_in[0];
    end
    if (do_wr) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      case (aw_idx)
        BIT_RATE_DIVISOR_IDX: begin
          if (q.w_lane) begin
            n.divisor = q.w_byte;
          end
        end
        SERIAL_LINE_STATUS_IDX: begin
          // only zeros clear, and only armed flags; ones are ignored
          if (q.w_lane) begin
            sw_clr = q.armed & ~q.w_byte[7:FLAG_LSB];
          end
        end
        SERIAL_CONTROL_IDX: begin
          if (q.w_lane) begin
            n.ctrl     = q.w_byte;
            tx_en_fall = q.ctrl[C_TX_EN] && !q.w_byte[C_TX_EN];
          end
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end

    // transmit side
    hw_set[F_TX_EMPTY] = tx_load_in || tx_en_fall;
    hw_clr[F_TX_EMPTY] = xfer_tx_write_in;

    // receive side: a busy buffer keeps the old byte
    hw_clr[F_RX_FULL] = xfer_rx_read_in;
    if (rx_done_in) begin
      if (q.flags[F_RX_FULL]) begin
        hw_set[F_OVERRUN] = 1'b1;
      end else begin
        framing_hit = !rx_stop_bit_in;
        parity_hit  = !q.ctrl[C_SYNC_MODE] && q.ctrl[C_PARITY_EN]
                      && rx_parity_bad_in;
        hw_set[F_FRAMING] = framing_hit;
        hw_set[F_PARITY]  = parity_hit;
        hw_set[F_RX_FULL] = !framing_hit && !parity_hit;
        n.rx_load         = !framing_hit && !parity_hit;
      end
    end

    // a set in the same cycle as a clear wins
    n.flags = (q.flags & ~sw_clr & ~hw_clr) | hw_set;
    n.armed = n.armed & n.flags & ~sw_clr & ~hw_clr;

    // post divider: 64 in async, 8 in sync
    if (gen_tick) begin
      if (q.post_cnt == (q.ctrl[C_SYNC_MODE] ? SYNC_POST_LAST
                                              : ASYNC_POST_LAST)) begin
        n.post_cnt = '0;
        n.bit_tick = 1'b1;
      end else begin
        n.post_cnt = q.post_cnt + 6'h01;
      end
    end

    if (standby_in) begin
      n.flags    = STATUS_RESET[7:FLAG_LSB];
      n.armed    = '0;
      n.divisor  = DIVISOR_RESET;
      n.ctrl     = CTRL_RESET;
      n.post_cnt = '0;
      n.bit_tick = 1'b0;
      n.rx_load  = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q         <= '0;
      q.flags   <= STATUS_RESET[7:FLAG_LSB];
      q.divisor <= DIVISOR_RESET;
      q.ctrl    <= CTRL_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready_out = !q.aw_held;
  assign s_axi_wready_out  = !q.w_held;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_rvalid_out  = q.rvalid;
  assign s_axi_rdata_out   = {24'h000000, q.rdata};
  assign s_axi_rresp_out   = q.rresp;

  assign rx_buffer_load_out  = q.rx_load;
  assign bit_tick_out        = q.bit_tick;
  assign transmit_enable_out = q.ctrl[C_TX_EN];
  assign sync_mode_out       = q.ctrl[C_SYNC_MODE];

  assign rx_complete_request_out = q.ctrl[C_RX_IE]
                                   && q.flags[F_RX_FULL];
  assign rx_error_request_out    = q.ctrl[C_RX_IE]
                                   && (q.flags[F_OVERRUN]
                                   || q.flags[F_FRAMING]
                                   || q.flags[F_PARITY]);
  assign tx_empty_request_out    = q.ctrl[C_TX_IE] && q.flags[F_TX_EMPTY];

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_standby_init;
    standby_in |=> q.flags == STATUS_RESET[7:FLAG_LSB]
                   && q.divisor == DIVISOR_RESET;
  endproperty
  a_standby_init: assert property (p_standby_init)
    else $error("standby did not load status and divisor");

  property p_tx_empty_set;
    tx_load_in && !standby_in |=> q.flags[F_TX_EMPTY];
  endproperty
  a_tx_empty_set: assert property (p_tx_empty_set)
    else $error("tx empty flag not set by shift load");

  property p_tx_empty_xfer;
    xfer_tx_write_in && !tx_load_in && !tx_en_fall && !standby_in
      |=> !q.flags[F_TX_EMPTY];
  endproperty
  a_tx_empty_xfer: assert property (p_tx_empty_xfer)
    else $error("tx empty flag not cleared by controller write");

  property p_tx_en_fall;
    tx_en_fall && !standby_in |=> q.flags[F_TX_EMPTY];
  endproperty
  a_tx_en_fall: assert property (p_tx_en_fall)
    else $error("tx empty flag not set when transmit disabled");

  property p_rx_full_cause;
    $rose(q.flags[F_RX_FULL]) |-> q.rx_load && $past(rx_done_in);
  endproperty
  a_rx_full_cause: assert property (p_rx_full_cause)
    else $error("rx full flag set without clean reception");

  property p_overrun;
    rx_done_in && q.flags[F_RX_FULL] && !standby_in
      |=> q.flags[F_OVERRUN] && !q.rx_load;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or new byte loaded");

  property p_framing;
    rx_done_in && !q.flags[F_RX_FULL] && !rx_stop_bit_in && !standby_in
      |=> q.flags[F_FRAMING] && !q.flags[F_RX_FULL];
  endproperty
  a_framing: assert property (p_framing)
    else $error("framing error not flagged");

  property p_parity_mode;
    $rose(q.flags[F_PARITY])
      |-> !$past(q.ctrl[C_SYNC_MODE]) && $past(q.ctrl[C_PARITY_EN]);
  endproperty
  a_parity_mode: assert property (p_parity_mode)
    else $error("parity flag set outside async parity mode");

  property p_clear_needs_read;
    $fell(q.flags[F_FRAMING])
      |-> $past(q.armed[F_FRAMING]) || $past(standby_in);
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read)
    else $error("error flag cleared without prior read");

  property p_reserved_ones;
    s_axi_arvalid_in && !q.rvalid && ar_idx == SERIAL_LINE_STATUS_IDX
      |=> q.rvalid && q.rdata[FLAG_LSB-1:0] == STATUS_FIXED;
  endproperty
  a_reserved_ones: assert property (p_reserved_ones)
    else $error("status low bits not read as ones");

  c_overrun: cover property (rx_done_in && q.flags[F_RX_FULL]);
  c_sw_clear: cover property (|sw_clr);
  c_bit_tick: cover property (q.bit_tick);

endmodule // serial_status_and_bit_rate

/* File: bench/serial_far_end.sv */
module serial_far_end
(
  // clock
  input  wire logic mclk_in,
  // from the block
  input  wire logic rx_buffer_load_in,
  // shifter and transfer controller events
  output logic      tx_load_out,
  output logic      xfer_tx_write_out,
  output logic      xfer_rx_read_out,
  output logic      rx_done_out,
  output logic      rx_stop_bit_out,
  output logic      rx_parity_bad_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] ev = 3'h0;

  assign tx_load_out      = ev[0];
  assign xfer_tx_write_out = ev[1];
  assign xfer_rx_read_out  = ev[2];

  initial begin
    rx_done_out = 1'b0;
    rx_stop_bit_out = 1'b1;
    rx_parity_bad_out = 1'b0;
  end

  // =========================================================
  // strobes: 0 buffer to shifter, 1 controller write, 2 controller read
  task automatic strobe(input int k);
    @(posedge mclk_in);
    ev[k] <= 1'b1;
    @(posedge mclk_in);
    ev <= 3'h0;
  endtask

  // =========================================================
  // a finished reception; stop and parity lines are only valid with
  // the strobe, so they are turned over afterwards to expose misuse
  task automatic frame(input logic stop, input logic bad,
                       output logic loaded);
    @(posedge mclk_in);
    rx_done_out <= 1'b1;
    rx_stop_bit_out <= stop;
    rx_parity_bad_out <= bad;
    @(posedge mclk_in);
    rx_done_out <= 1'b0;
    rx_stop_bit_out <= ~stop;
    rx_parity_bad_out <= ~bad;
    @(posedge mclk_in);
    loaded = rx_buffer_load_in;
  endtask
endmodule // serial_far_end

/* File: bench/test_serial_status_and_bit_rate.sv */
module test_serial_status_and_bit_rate;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_status_pkg::*;

  // =========================================================
  // signals
  logic        mclk_in = 1'b0, nrst_in = 1'b0, standby_in = 1'b0;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic        s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
  logic        s_axi_rready_in = 1'b0;
  logic [17:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, resp;
  logic [31:0] s_axi_rdata_out, rd_data;
  logic        tx_load_in, xfer_tx_write_in, xfer_rx_read_in;
  logic        rx_done_in, rx_stop_bit_in, rx_parity_bad_in, ld;
  logic        rx_buffer_load_out, bit_tick_out, transmit_enable_out;
  logic        sync_mode_out, rx_complete_request_out;
  logic        rx_error_request_out, tx_empty_request_out;
  int          bad_count = 0;
  int          n_tests = 0;

  localparam logic [17:0] A_DIV = {BIT_RATE_DIVISOR_IDX, 2'b00};
  localparam logic [17:0] A_STS = {SERIAL_LINE_STATUS_IDX, 2'b00};
  localparam logic [17:0] A_CTL = {SERIAL_CONTROL_IDX, 2'b00};
  localparam logic [17:0] A_BAD = 18'h00010;

  always #5 mclk_in = ~mclk_in;

  serial_status_and_bit_rate #(.ADDR_W(18)) u_serial_status_and_bit_rate (
    .mclk_in, .nrst_in, .standby_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
    .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
    .tx_load_in, .xfer_tx_write_in, .xfer_rx_read_in, .rx_done_in,
    .rx_stop_bit_in, .rx_parity_bad_in, .rx_buffer_load_out, .bit_tick_out,
    .transmit_enable_out, .sync_mode_out, .rx_complete_request_out,
    .rx_error_request_out, .tx_empty_request_out);

  serial_far_end u_serial_far_end (
    .mclk_in, .rx_buffer_load_in(rx_buffer_load_out),
    .tx_load_out(tx_load_in), .xfer_tx_write_out(xfer_tx_write_in),
    .xfer_rx_read_out(xfer_rx_read_in), .rx_done_out(rx_done_in),
    .rx_stop_bit_out(rx_stop_bit_in), .rx_parity_bad_out(rx_parity_bad_in));

  // =========================================================
  // checks and bus access
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge mclk_in);
      if (!aw_done && s_axi_awready_out) begin
        aw_done = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w_done && s_axi_wready_out) begin
        w_done = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge mclk_in); while (!s_axi_bvalid_out);
    resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a);
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge mclk_in); while (!s_axi_rvalid_out);
    rd_data = s_axi_rdata_out;
    resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic rc(input string what, input logic [17:0] a,
                    input logic [7:0] exp);
    rd(a);
    chk(what, {24'h0, exp}, rd_data);
  endtask

  task automatic frm(input logic s, input logic b, input logic exp_ld);
    u_serial_far_end.frame(s, b, ld);
    chk("buffer load", 32'(exp_ld), 32'(ld));
  endtask

  // counters may be mid-period after a write, and the gap after the
  // first tick can still hold a reload of the old divisor, so two
  // ticks are skipped as markers before the gap is measured
  task automatic per(input logic [7:0] ctl, dv, input int exp);
    int c;
    wr(A_CTL, ctl);
    wr(A_DIV, dv);
    do @(posedge mclk_in); while (!bit_tick_out);
    do @(posedge mclk_in); while (!bit_tick_out);
    c = 0;
    do begin
      @(posedge mclk_in);
      c++;
    end while (!bit_tick_out);
    chk("bit period", exp, c);
  endtask

  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // =========================================================
  // tests
  logic [7:0] pc [5] = '{8'h00, 8'h01, 8'h04, 8'h03, 8'h05};
  logic [7:0] pd [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h02};
  int         pe [5] = '{64, 512, 8, 4096, 96};

  initial begin
    #500us;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    wr(A_STS, 8'h00);
    rc("status", A_STS, 8'h87);
    rc("divisor", A_DIV, 8'hFF);
    wr(A_STS, 8'hFF);
    rc("status", A_STS, 8'h87);
    wr(A_STS, 8'h00);
    rc("status", A_STS, 8'h07);
    u_serial_far_end.strobe(0);
    rc("status", A_STS, 8'h87);
    u_serial_far_end.strobe(1);
    rc("status", A_STS, 8'h07);
    wr(A_CTL, 8'h20);
    chk("transmit enable", 32'h1, 32'(transmit_enable_out));
    wr(A_CTL, 8'h00);
    rc("status", A_STS, 8'h87);
    frm(1'b1, 1'b0, 1'b1);
    rc("status", A_STS, 8'hC7);
    frm(1'b1, 1'b0, 1'b0);
    rc("status", A_STS, 8'hE7);
    wr(A_STS, 8'hBF);
    rc("status", A_STS, 8'hA7);
    wr(A_STS, 8'hDF);
    rc("status", A_STS, 8'h87);
    frm(1'b1, 1'b0, 1'b1);
    u_serial_far_end.strobe(2);
    rc("status", A_STS, 8'h87);
    frm(1'b0, 1'b0, 1'b0);
    rc("status", A_STS, 8'h97);
    wr(A_STS, 8'hEF);
    rc("status", A_STS, 8'h87);
    wr(A_CTL, 8'h08);
    frm(1'b1, 1'b1, 1'b0);
    rc("status", A_STS, 8'h8F);
    wr(A_STS, 8'hF7);
    rc("status", A_STS, 8'h87);
    wr(A_CTL, 8'h0C);
    chk("sync mode", 32'h1, 32'(sync_mode_out));
    frm(1'b1, 1'b1, 1'b1);
    wr(A_CTL, 8'hC0);
    chk("requests", 32'({rx_complete_request_out, rx_error_request_out,
        tx_empty_request_out}), 32'h5);
    frm(1'b0, 1'b0, 1'b0);
    chk("requests", 32'({rx_complete_request_out, rx_error_request_out,
        tx_empty_request_out}), 32'h7);
    wr(A_CTL, 8'h00);
    chk("requests", 32'({rx_complete_request_out, rx_error_request_out,
        tx_empty_request_out}), 32'h0);
    wr(A_DIV, 8'h05);
    rc("divisor", A_DIV, 8'h05);
    s_axi_wstrb_in <= 4'hE;
    wr(A_DIV, 8'h33);
    s_axi_wstrb_in <= 4'hF;
    rc("divisor", A_DIV, 8'h05);
    @(posedge mclk_in);
    standby_in <= 1'b1;
    @(posedge mclk_in);
    standby_in <= 1'b0;
    rc("status", A_STS, 8'h87);
    rc("divisor", A_DIV, 8'hFF);
    rc("control", A_CTL, 8'h00);
    rd(A_BAD);
    chk("unmapped data", 32'h0, rd_data);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
    wr(A_BAD, 8'h12);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
    foreach (pc[i]) per(pc[i], pd[i], pe[i]);
    stop_test();
  end
endmodule // test_serial_status_and_bit_rate
